// ### hw/rri_pkg.sv
// Package: register map, field layout, sizes and carriers of the raster read window and tap interleaver
package rri_pkg;

    localparam int PIX_W = 8;
    localparam int ADDR_W = 12;
    localparam int NUM_TAPS = 4;
    localparam int LINE_PIXELS = 4096;
    localparam int IDX_W = 8;
    localparam int POS_W = 16;

    // Register indices; byte address is four times the index, one byte per word
    localparam logic [IDX_W-1:0] IDX_CONFIG_A = 8'h40;
    localparam logic [IDX_W-1:0] IDX_HCOUNT_MAX_LO = 8'h48;
    localparam logic [IDX_W-1:0] IDX_LV_START_LO = 8'h54;
    localparam logic [IDX_W-1:0] IDX_LV_END_LO = 8'h56;
    localparam logic [IDX_W-1:0] IDX_RV_START_LO = 8'h58;
    localparam logic [IDX_W-1:0] IDX_RV_END_LO = 8'h5A;
    localparam logic [IDX_W-1:0] IDX_TAP_BASE = 8'h60;
    localparam logic [IDX_W-1:0] IDX_FILL_FIRST = 8'h70;
    localparam logic [IDX_W-1:0] IDX_FILL_SECOND = 8'h71;
    localparam logic [IDX_W-1:0] IDX_HPOS_LO = 8'h72;
    localparam logic [IDX_W-1:0] IDX_HPOS_HI = 8'h73;
    localparam logic [IDX_W-1:0] IDX_HI_BYTE = 8'h01;
    localparam logic [IDX_W-1:0] TAP_STRIDE = 8'h04;
    localparam logic [IDX_W-1:0] TAP_STEP_OFS = 8'h02;

    // Byte bank covers indices 0x40 to 0x73
    localparam logic [IDX_W-1:0] IDX_BANK_BASE = 8'h40;
    localparam int BANK_SLOTS = 52;

    // Configuration register A fields
    localparam int CFG_BIT_RW_EN = 0;
    localparam int CFG_BIT_TEST_CNT = 1;
    localparam int CFG_BIT_ILV_EN = 2;

    localparam logic [POS_W-1:0] HCOUNT_MAX_RESET = 16'h04FF;

    typedef logic [NUM_TAPS-1:0][ADDR_W-1:0] rri_tap_vec_t;

    typedef struct packed {
        logic lineValid;
        logic [PIX_W-1:0] data;
    } rri_pixel_t;

endpackage

// ### hw/rri_tap_walker.sv
// Four-tap address walker that picks the raster pixel to emit next
`timescale 1ns/1ps
module rri_tap_walker import rri_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reload,
    input wire logic step,
    input wire rri_tap_vec_t starts,
    input wire rri_tap_vec_t steps,
    output logic [ADDR_W-1:0] addr
);

    rri_tap_vec_t acc_q;
    logic [1:0] tapSel_q;

    // Signed step in twelve bits: the sum wraps modulo 4096
    function automatic logic [ADDR_W-1:0] wrapAdd(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        return a + b;
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q <= '0;
            tapSel_q <= 2'h0;
        end else if (reload) begin
            acc_q <= starts;
            tapSel_q <= 2'h0;
        end else if (step) begin
            acc_q[tapSel_q] <= wrapAdd(acc_q[tapSel_q], steps[tapSel_q]);
            tapSel_q <= tapSel_q + 2'h1;
        end
    end

    assign addr = acc_q[tapSel_q];

    tap_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
        reload |=> addr == $past(starts[0]) && tapSel_q == 2'h0)
        else $error("Tap walker did not restart from tap 0 start");
    tap_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        step && !reload |=> acc_q[$past(tapSel_q)] == $past(acc_q[tapSel_q] + steps[tapSel_q]))
        else $error("Tap address did not advance by its step");

endmodule

// ### hw/rri_line_store.sv
// Two-bank raster store: one bank fills while the other is read back reordered
`timescale 1ns/1ps
module rri_line_store import rri_pkg::*; (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [ADDR_W:0] wrAddr,
    input wire logic [PIX_W-1:0] wrData,
    input wire logic [ADDR_W:0] rdAddr,
    output logic [PIX_W-1:0] rdData
);

    logic [PIX_W-1:0] mem_q [0:2*LINE_PIXELS-1];

    // No reset: image contents carry no control meaning
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem_q[wrAddr] <= wrData;
        end
        rdData <= mem_q[rdAddr];
    end

endmodule

// ### hw/rri_raster_interleaver.sv
// Raster line/read window timing, pixel source select and four-tap interleaver with APB registers
// Summary of operation
// - Line valid drops when the raster position equals the line valid end value.
// - Read-from-DMA rises at the read window start position while the window is enabled.
// - Read-from-DMA falls at the read window end position while the window is enabled.
// - Outside the read window pixels come from the first or second fill value.
// - With test counter selected, the counter replaces the DMA stream inside the window.
// - Window disabled: positions ignored, read-from-DMA follows line valid exactly.
// - Interleaver runs only with configuration bit 2 set; otherwise pixels pass in order.
// - With interleaving, outgoing pixels pass through the reordering store.
// - At most 4096 active eight-bit pixels per raster are kept for interleaving.
// - Only the low twelve bits of each tap register are used.
// - The interleaver always works as four taps, each with start and step.
// - Each tap address advances by its step from its start value.
// - Tap steps are signed two's complement, so taps may walk leftward.
// - Tap zero start is a sixteen-bit register, low byte at the lower address.
// - Line valid rises when the raster position equals the line valid start value.
// - Each tap has a sixteen-bit read-write step register, low byte first.
// - Taps one to three have start registers following the previous step register.
`timescale 1ns/1ps
module rri_raster_interleaver import rri_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pixClk,
    input wire logic [PIX_W-1:0] dmaData,
    output logic dmaTake,
    output logic readWindow,
    output rri_pixel_t pixOut
);

    logic [PIX_W-1:0] bank_q [0:BANK_SLOTS-1];
    logic [PIX_W-1:0] act_q [0:BANK_SLOTS-1];
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic pixMeta_q;
    logic pixSync_q;
    logic pixPrev_q;
    logic [POS_W-1:0] hPos_q;
    rri_pixel_t pixOut_q;
    logic readWindow_q;
    logic rdSeen_q;
    logic [PIX_W-1:0] testCount_q;
    logic dmaTake_q;
    logic [ADDR_W:0] wrCount_q;
    logic bankSel_q;
    logic rasterStart_q;

    function automatic logic [5:0] slot(input logic [IDX_W-1:0] idx);
        return 6'(idx - IDX_BANK_BASE);
    endfunction

    // Word view of the active set; a plain select, so the assigns below follow every copy
    wire [POS_W-1:0] actPair [0:BANK_SLOTS-2];
    for (genvar s = 0; s < BANK_SLOTS - 1; s++) begin : g_pair
        assign actPair[s] = {act_q[s + int'(IDX_HI_BYTE)], act_q[s]};
    end

    function automatic logic [PIX_W-1:0] resetByte(input int i);
        if (i == int'(slot(IDX_HCOUNT_MAX_LO))) begin
            return HCOUNT_MAX_RESET[7:0];
        end else if (i == int'(slot(IDX_HCOUNT_MAX_LO + IDX_HI_BYTE))) begin
            return HCOUNT_MAX_RESET[15:8];
        end
        return 8'h00;
    endfunction

    function automatic logic isMapped(input logic [IDX_W-1:0] idx);
        return (idx == IDX_CONFIG_A) || (idx == IDX_HCOUNT_MAX_LO) || (idx == IDX_HCOUNT_MAX_LO + IDX_HI_BYTE)
            || (idx >= IDX_LV_START_LO && idx <= IDX_RV_END_LO + IDX_HI_BYTE)
            || (idx >= IDX_TAP_BASE && idx <= IDX_HPOS_HI);
    endfunction

    // Open/close tracker shared by line valid and the read window; close wins a tie
    function automatic logic winNext(input logic openHit, input logic closeHit, input logic cur);
        return closeHit ? 1'b0 : (openHit ? 1'b1 : cur);
    endfunction

    // APB decode
    wire [IDX_W-1:0] regIdx = paddr[IDX_W+1:2];
    wire regHit = isMapped(regIdx) && (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    wire regWrOk = regHit && (regIdx < IDX_HPOS_LO);
    wire [5:0] bankIdx = slot(regIdx);
    wire apbSetup = psel && !penable;
    wire apbWrite = psel && penable && pready_q && pwrite && regWrOk;
    wire [PIX_W-1:0] rdByte = (regIdx == IDX_HPOS_LO) ? hPos_q[7:0] :
                              (regIdx == IDX_HPOS_HI) ? hPos_q[15:8] :
                              regHit ? bank_q[bankIdx] : 8'h00;

    // Configuration A acts at once; positions, taps and fills from the raster-aligned copy
    wire [PIX_W-1:0] cfgA = bank_q[slot(IDX_CONFIG_A)];
    wire rwEnable = cfgA[CFG_BIT_RW_EN];
    wire testSel = cfgA[CFG_BIT_TEST_CNT];
    wire ilvEnable = cfgA[CFG_BIT_ILV_EN];
    wire [POS_W-1:0] hCntMax = actPair[slot(IDX_HCOUNT_MAX_LO)];
    wire [POS_W-1:0] lvStart = actPair[slot(IDX_LV_START_LO)];
    wire [POS_W-1:0] lvEnd = actPair[slot(IDX_LV_END_LO)];
    wire [POS_W-1:0] rvStart = actPair[slot(IDX_RV_START_LO)];
    wire [POS_W-1:0] rvEnd = actPair[slot(IDX_RV_END_LO)];
    wire [PIX_W-1:0] fillFirst = act_q[slot(IDX_FILL_FIRST)];
    wire [PIX_W-1:0] fillSecond = act_q[slot(IDX_FILL_SECOND)];

    rri_tap_vec_t tapStarts;
    rri_tap_vec_t tapSteps;
    for (genvar t = 0; t < NUM_TAPS; t++) begin : g_tap
        wire [POS_W-1:0] startWord = actPair[slot(IDX_TAP_BASE + 8'(TAP_STRIDE * t))];
        wire [POS_W-1:0] stepWord = actPair[slot(IDX_TAP_BASE + 8'(TAP_STRIDE * t) + TAP_STEP_OFS)];
        assign tapStarts[t] = startWord[ADDR_W-1:0];
        assign tapSteps[t] = stepWord[ADDR_W-1:0];
    end

    // Pixel timing
    wire pixEn = pixSync_q && !pixPrev_q;
    wire rasterEnd = pixEn && (hPos_q == hCntMax);
    wire lvNow = winNext(hPos_q == lvStart, hPos_q == lvEnd, pixOut_q.lineValid);
    wire rdWin = winNext(hPos_q == rvStart, hPos_q == rvEnd, readWindow_q);
    wire rdNow = rwEnable ? rdWin : lvNow;
    wire pixActive = pixEn && lvNow;
    wire consume = pixActive && rdNow;

    // Source select: fill before the window opens uses the first value, after it the second
    wire [PIX_W-1:0] fillNow = rdSeen_q ? fillSecond : fillFirst;
    wire [PIX_W-1:0] streamNow = testSel ? testCount_q : dmaData;
    wire [PIX_W-1:0] directNow = rdNow ? streamNow : fillNow;

    // Interleave store: write in order into one bank, read the other through the taps
    wire bufWrite = pixActive && !wrCount_q[ADDR_W];
    wire tapStep = pixActive && ilvEnable;
    wire [ADDR_W-1:0] tapAddr;
    wire [PIX_W-1:0] bufRdData;
    wire [PIX_W-1:0] outNow = ilvEnable ? bufRdData : directNow;

    // Taps reload one cycle after the boundary, once the new starts sit in the active set
    rri_tap_walker u_taps (
        .clk(clk),
        .rst_n(rst_n),
        .reload(rasterStart_q),
        .step(tapStep),
        .starts(tapStarts),
        .steps(tapSteps),
        .addr(tapAddr)
    );

    rri_line_store u_store (
        .clk(clk),
        .wrEn(bufWrite),
        .wrAddr({bankSel_q, wrCount_q[ADDR_W-1:0]}),
        .wrData(directNow),
        .rdAddr({!bankSel_q, tapAddr}),
        .rdData(bufRdData)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apbSetup;
            pslverr_q <= apbSetup && !regHit;
            prdata_q <= apbSetup ? {24'h00_0000, rdByte} : prdata_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < BANK_SLOTS; i++) begin
                bank_q[i] <= resetByte(i);
            end
        end else if (apbWrite) begin
            bank_q[bankIdx] <= pwdata[PIX_W-1:0];
        end
    end

    // Byte writes land whole at the boundary, so a half-written word never drives timing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < BANK_SLOTS; i++) begin
                act_q[i] <= resetByte(i);
            end
        end else if (rasterEnd) begin
            act_q <= bank_q;
        end
    end

    // Pixel clock pin is sampled by clk; only the second and third stages are looked at
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pixMeta_q <= 1'b0;
            pixSync_q <= 1'b0;
            pixPrev_q <= 1'b0;
        end else begin
            pixMeta_q <= pixClk;
            pixSync_q <= pixMeta_q;
            pixPrev_q <= pixSync_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hPos_q <= 16'h0000;
            pixOut_q <= '0;
            readWindow_q <= 1'b0;
            rdSeen_q <= 1'b0;
        end else if (pixEn) begin
            hPos_q <= rasterEnd ? 16'h0000 : hPos_q + 16'h0001;
            pixOut_q.lineValid <= lvNow;
            pixOut_q.data <= outNow;
            readWindow_q <= rdNow;
            rdSeen_q <= !rasterEnd && (rdSeen_q || rdNow);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            testCount_q <= 8'h00;
            dmaTake_q <= 1'b0;
            wrCount_q <= 13'h0000;
            bankSel_q <= 1'b0;
            rasterStart_q <= 1'b0;
        end else begin
            testCount_q <= (consume && testSel) ? testCount_q + 8'h01 : testCount_q;
            dmaTake_q <= consume && !testSel;
            wrCount_q <= rasterEnd ? 13'h0000 : (bufWrite ? wrCount_q + 13'h0001 : wrCount_q);
            bankSel_q <= rasterEnd ? !bankSel_q : bankSel_q;
            rasterStart_q <= rasterEnd;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dmaTake = dmaTake_q;
    assign readWindow = readWindow_q;
    assign pixOut = pixOut_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    lv_end_a: assert property (pixEn && hPos_q == lvEnd |=> !pixOut.lineValid)
        else $error("Line valid stayed high at its end position");
    lv_start_a: assert property (pixEn && hPos_q == lvStart && hPos_q != lvEnd |=> pixOut.lineValid)
        else $error("Line valid did not rise at its start position");
    rd_open_a: assert property (pixEn && rwEnable && hPos_q == rvStart && hPos_q != rvEnd |=> readWindow)
        else $error("Read window did not open at its start position");
    rd_close_a: assert property (pixEn && rwEnable && hPos_q == rvEnd |=> !readWindow)
        else $error("Read window did not close at its end position");
    rd_follow_a: assert property (pixEn && !rwEnable |=> readWindow == pixOut.lineValid)
        else $error("Read window does not follow line valid while disabled");
    fill_out_a: assert property (pixActive && !rdNow && !ilvEnable
        |=> pixOut.data == $past(fillNow) && !dmaTake)
        else $error("Fill value not sent outside the read window");
    test_src_a: assert property (consume && testSel && !ilvEnable
        |=> pixOut.data == $past(testCount_q) && !dmaTake)
        else $error("Test counter not used in place of the stream");
    pass_order_a: assert property (pixEn && !ilvEnable |=> pixOut.data == $past(directNow))
        else $error("Pixel reordered while interleaving is off");
    ilv_route_a: assert property (pixEn && ilvEnable |=> pixOut.data == $past(bufRdData))
        else $error("Interleaved pixel not taken from the store");
    buf_limit_a: assert property (wrCount_q <= 13'(LINE_PIXELS))
        else $error("Store write count ran past one raster");
    shadow_hold_a: assert property (!rasterEnd |=> $stable(lvEnd) && $stable(tapStarts))
        else $error("Active register changed away from a raster boundary");

    lv_hold_a: assert property (pixEn && hPos_q != lvStart && hPos_q != lvEnd |=> pixOut.lineValid == $past(pixOut.lineValid))
        else $error("Line valid moved away from its start and end positions");
    rd_hold_a: assert property (pixEn && rwEnable && hPos_q != rvStart && hPos_q != rvEnd |=> readWindow == $past(readWindow))
        else $error("Read window moved away from its start and end positions");
    fill_first_a: assert property (pixActive && !rdNow && !rdSeen_q && !ilvEnable
        |=> pixOut.data == $past(fillFirst))
        else $error("First fill value not sent before the read window");
    fill_second_a: assert property (pixActive && !rdNow && rdSeen_q && !ilvEnable
        |=> pixOut.data == $past(fillSecond))
        else $error("Second fill value not sent after the read window");
    no_take_a: assert property (!consume |=> !dmaTake)
        else $error("Stream advanced for a pixel that did not consume it");
    dma_take_a: assert property (consume && !testSel |=> dmaTake)
        else $error("Stream not advanced after a consumed pixel");

    // Between pixels the pixel output and the read window hold
    pix_hold_a: assert property (!pixEn |=> $stable(pixOut) && $stable(readWindow))
        else $error("Pixel output changed between pixel clocks");
    raster_wrap_a: assert property (rasterStart_q |-> hPos_q == 16'h0000)
        else $error("Tap reload not at the start of a raster");

    lv_rise_c: cover property (pixEn && !pixOut.lineValid ##1 pixOut.lineValid);
    fill_send_c: cover property (pixActive && !rdNow && rdSeen_q);
    dma_take_c: cover property (dmaTake ##[1:20] dmaTake);
    ilv_pixel_c: cover property (tapStep && tapAddr != 12'h000);
    neg_step_c: cover property (tapStep && tapSteps[1][ADDR_W-1]);

endmodule

// ### testbench/rri_grabber_model.sv
// Far-side model: free-running pixel clock and a DMA byte source that advances on each take
`timescale 1ns/1ps
module rri_grabber_model import rri_pkg::*; #(
    parameter logic [PIX_W-1:0] DMA_STEP = 8'h03
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dmaTake,
    output logic pixClk,
    output logic [PIX_W-1:0] dmaData
);
    // Pixel clock runs free, phase offset so its edges never meet clk edges
    initial begin
        pixClk = 1'b0;
        #7;
        forever #100 pixClk = ~pixClk;
    end

    // Step of 3, not 1, so the stream is told apart from the test counter
    always @(posedge clk) begin
        if (!rst_n) begin
            dmaData <= 8'h10;
        end else if (dmaTake === 1'b1) begin
            dmaData <= dmaData + DMA_STEP;
        end
    end
endmodule

// ### testbench/tb_rri_raster_interleaver.sv
// Self-checking bench: registers over APB, line and read window timing, sources, interleaving
`timescale 1ns/1ps
module tb_rri_raster_interleaver import rri_pkg::*; ;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pixClk, dmaTake, readWindow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [PIX_W-1:0] dmaData;
    rri_pixel_t pixOut;
    int errors, tests_run, cycleCount;
    logic lvS [24];
    logic rwS [24];
    logic [7:0] dS [24];
    logic [11:0] tapStart [2][4] = '{'{12'h000, 12'h008, 12'h001, 12'h009}, '{12'h000, 12'h00F, 12'h001, 12'h00E}};
    logic [11:0] tapStep [2][4] = '{'{12'h002, 12'h002, 12'h002, 12'h002}, '{12'h002, 12'hFFE, 12'h002, 12'hFFE}};

    rri_raster_interleaver i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pixClk(pixClk),
        .dmaData(dmaData), .dmaTake(dmaTake), .readWindow(readWindow), .pixOut(pixOut));
    rri_grabber_model i_grabber (.clk(clk), .rst_n(rst_n), .dmaTake(dmaTake), .pixClk(pixClk), .dmaData(dmaData));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Run is about 13k cycles; about three times that means a hang
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 40000) begin
            errors++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, v, r, e);
    endtask

    task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
        wr(idx, v[7:0]);
        wr(idx + 8'h01, v[15:8]);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic expErr);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        check(r, exp);
        check(32'(e), 32'(expErr));
    endtask

    // Samples each pixel at the falling pixel clock edge, well after it settled
    task automatic grab();
        do @(negedge pixClk); while (pixOut.lineValid !== 1'b0);
        do @(negedge pixClk); while (pixOut.lineValid !== 1'b1);
        for (int i = 0; i < 24; i++) begin
            lvS[i] = pixOut.lineValid;
            rwS[i] = readWindow;
            dS[i] = pixOut.data;
            @(negedge pixClk);
        end
    endtask

    // Line valid 4..19, window 8..13 relative to a 32-position raster
    task automatic windowCheck(input logic [7:0] step);
        grab();
        for (int i = 0; i < 24; i++) begin
            check(32'(lvS[i]), 32'(i < 16));
            check(32'(rwS[i]), 32'(i >= 4 && i < 10));
            if (i < 4) check(32'(dS[i]), 32'h000000A1);
            if (i >= 10 && i < 16) check(32'(dS[i]), 32'h000000B2);
            if (i > 4 && i < 10) check(32'(dS[i]), 32'(8'(dS[i-1] + step)));
        end
    endtask

    task automatic tapCheck(input int p);
        logic [11:0] a;
        for (int t = 0; t < 4; t++) begin
            wr16(IDX_TAP_BASE + TAP_STRIDE * 8'(t), {4'h0, tapStart[p][t]});
            wr16(IDX_TAP_BASE + TAP_STRIDE * 8'(t) + TAP_STEP_OFS, {4'hA, tapStep[p][t]});
        end
        // Output lags a raster and taps load at the boundary
        repeat (3) grab();
        for (int k = 0; k < 16; k++) begin
            a = tapStart[p][k % 4] + tapStep[p][k % 4] * 12'(k / 4);
            check(32'(dS[k]), 32'(8'(dS[0] + 8'(a) * 8'h03)));
        end
    endtask

    initial begin
        logic [7:0] idx;
        logic [31:0] r;
        logic e;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdchk(IDX_HCOUNT_MAX_LO, 32'h000000FF, 1'b0);
        rdchk(IDX_HCOUNT_MAX_LO + IDX_HI_BYTE, 32'h00000004, 1'b0);
        for (int i = 0; i < 24; i++) begin
            idx = (i < 8) ? 8'(IDX_LV_START_LO + i) : 8'(IDX_LV_START_LO + 4 + i);
            rdchk(idx, 32'h00000000, 1'b0);
            wr(idx, idx ^ 8'h5A);
            rdchk(idx, 32'(idx ^ 8'h5A), 1'b0);
        end
        rdchk(8'h30, 32'h00000000, 1'b1);
        apb(1'b1, 8'h30, 8'h77, r, e);
        check(32'(e), 32'h00000001);
        // Short raster keeps the run brief
        wr16(IDX_HCOUNT_MAX_LO, 16'h001F);
        wr16(IDX_LV_START_LO, 16'h0004);
        wr16(IDX_LV_END_LO, 16'h0014);
        wr16(IDX_RV_START_LO, 16'h0008);
        wr16(IDX_RV_END_LO, 16'h000E);
        wr(IDX_FILL_FIRST, 8'hA1);
        wr(IDX_FILL_SECOND, 8'hB2);
        wr(IDX_CONFIG_A, 8'h01);
        windowCheck(8'h03);
        wr(IDX_CONFIG_A, 8'h03);
        grab();
        windowCheck(8'h01);
        wr(IDX_CONFIG_A, 8'h00);
        grab();
        grab();
        for (int i = 0; i < 24; i++) begin
            check(32'(rwS[i]), 32'(i < 16));
            check(32'(lvS[i]), 32'(i < 16));
            if (i > 0 && i < 16) check(32'(dS[i]), 32'(8'(dS[i-1] + 8'h03)));
        end
        wr(IDX_CONFIG_A, 8'h04);
        tapCheck(0);
        tapCheck(1);
        conclude();
    end
endmodule
